// >>> wst_regs.svh
// register addresses, field positions and reset values of the wake-up system timer
`ifndef WST_REGS_SVH
`define WST_REGS_SVH

`define WST_ADDR_CONTROL 8'hD1
`define WST_ADDR_RELOAD_HIGH 8'hD2
`define WST_ADDR_RELOAD_LOW 8'hD3

`define WST_BIT_FLAG 7
`define WST_BIT_SEL_HI 6
`define WST_BIT_SEL_LO 5
`define WST_BIT_LOCAL_IRQ_EN 1
`define WST_BIT_ENABLE 0

`define WST_SEL_SYSTEM_CLOCK 2'h3
`define WST_RST_SEL 2'h3
`define WST_RST_RELOAD 8'h00
`define WST_RST_COUNT 23'h000000
`define WST_PRESCALE_ONES 7'h7F

`define WST_IRQ_ENABLE_REG0_BIT_SHARED 6
`define WST_IRQ_ENABLE_REG0_BIT_GLOBAL 7

`endif

// >>> wst_pkg.sv
// types of the wake-up system timer
package wst_pkg;

    typedef struct packed {
        logic [15:0] counter;
        logic [6:0] prescaler;
    } wst_count_type;

    typedef struct packed {
        logic terminal_count_flag;
        logic [1:0] source_select;
        logic local_irq_enable;
        logic timer_enable;
    } wst_control_type;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } wst_sfr_req_type;

    typedef struct packed {
        wst_count_type count;
        wst_control_type ctl;
        logic [7:0] reload_high_byte;
        logic [7:0] reload_low_byte;
        logic [7:0] rdata;
    } wst_state_type;

endpackage : wst_pkg

// >>> wst_timer.sv
// wake-up system timer: 23-bit reloading down counter behind special function registers
`timescale 1ns/100ps
`default_nettype none
`include "wst_regs.svh"

module wst_timer (
    input wire logic I_CLK_SYS,
    input wire logic I_RST,
    input wire logic [7:0] I_SFR_ADDR,
    input wire logic [7:0] I_SFR_WDATA,
    input wire logic I_SFR_WR,
    input wire logic I_SFR_RD,
    input wire logic I_SYSTEM_CLOCK_TICK,
    input wire logic I_CRYSTAL_OSC_TICK,
    input wire logic [7:0] I_IRQ_ENABLE_REG0,
    input wire logic I_WDT_IRQ,
    output logic [7:0] O_SFR_RDATA,
    output logic O_IRQ,
    output logic O_WAKEUP
);

    wst_pkg::wst_state_type st_q;
    wst_pkg::wst_state_type st_d;
    wst_pkg::wst_sfr_req_type req;
    logic tick;
    logic wr_ctl;
    logic enable_rise;
    logic terminal;
    logic shared_wdt_timer_irq_enable;
    logic global_irq_enable;

    assign req = '{addr: I_SFR_ADDR, wdata: I_SFR_WDATA, wr: I_SFR_WR, rd: I_SFR_RD};
    assign wr_ctl = req.wr && (req.addr == `WST_ADDR_CONTROL);

    // counter clock as an enable pulse; ticks keep coming in power-down
    always_comb begin
        if (st_q.ctl.source_select == `WST_SEL_SYSTEM_CLOCK) begin
            tick = I_SYSTEM_CLOCK_TICK;
        end else begin
            tick = I_CRYSTAL_OSC_TICK;
        end
    end

    assign enable_rise = wr_ctl && req.wdata[`WST_BIT_ENABLE] && !st_q.ctl.timer_enable;
    assign terminal = st_q.ctl.timer_enable && !enable_rise && tick
        && (st_q.count == `WST_RST_COUNT);

    always_comb begin
        st_d = st_q;
        // reload registers: plain storage, copied into the live count only on the enabling write or at terminal count
        if (req.wr && req.addr == `WST_ADDR_RELOAD_HIGH) begin
            st_d.reload_high_byte = req.wdata;
        end
        if (req.wr && req.addr == `WST_ADDR_RELOAD_LOW) begin
            st_d.reload_low_byte = req.wdata;
        end
        if (wr_ctl) begin
            st_d.ctl.timer_enable = req.wdata[`WST_BIT_ENABLE];
            st_d.ctl.local_irq_enable = req.wdata[`WST_BIT_LOCAL_IRQ_EN];
            if (!st_q.ctl.timer_enable) begin
                st_d.ctl.source_select =
                    req.wdata[`WST_BIT_SEL_HI:`WST_BIT_SEL_LO];
            end
            if (!req.wdata[`WST_BIT_FLAG]) begin
                st_d.ctl.terminal_count_flag = 1'b0;
            end
        end
        // counter
        if (!st_d.ctl.timer_enable) begin
            st_d.count = `WST_RST_COUNT;
        end else if (enable_rise) begin
            st_d.count = {st_q.reload_high_byte, st_q.reload_low_byte,
                `WST_PRESCALE_ONES};
        end else if (terminal) begin
            st_d.count = {st_q.reload_high_byte, st_q.reload_low_byte,
                `WST_PRESCALE_ONES};
        end else if (tick) begin
            st_d.count = st_q.count - 23'h000001;
        end
        // set wins over a clear in the same cycle
        if (terminal) begin
            st_d.ctl.terminal_count_flag = 1'b1;
        end
        // registered read data; unmapped addresses read zero
        if (req.rd) begin
            unique case (req.addr)
                `WST_ADDR_CONTROL: st_d.rdata = {st_q.ctl.terminal_count_flag,
                    st_q.ctl.source_select, 3'h0, st_q.ctl.local_irq_enable,
                    st_q.ctl.timer_enable};
                `WST_ADDR_RELOAD_HIGH: st_d.rdata = st_q.reload_high_byte;
                `WST_ADDR_RELOAD_LOW: st_d.rdata = st_q.reload_low_byte;
                default: st_d.rdata = 8'h00;
            endcase
        end
    end

    // I_RST is the power-on reset; other reset sources never reach this block
    always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            st_q.count <= `WST_RST_COUNT;
            st_q.ctl.terminal_count_flag <= 1'b0;
            st_q.ctl.source_select <= `WST_RST_SEL;
            st_q.ctl.local_irq_enable <= 1'b0;
            st_q.ctl.timer_enable <= 1'b0;
            st_q.reload_high_byte <= `WST_RST_RELOAD;
            st_q.reload_low_byte <= `WST_RST_RELOAD;
            st_q.rdata <= 8'h00;
        end else begin
            st_q <= st_d;
        end
    end

    assign shared_wdt_timer_irq_enable = I_IRQ_ENABLE_REG0[`WST_IRQ_ENABLE_REG0_BIT_SHARED];
    assign global_irq_enable = I_IRQ_ENABLE_REG0[`WST_IRQ_ENABLE_REG0_BIT_GLOBAL];
    assign O_SFR_RDATA = st_q.rdata;
    // shared vector with the watchdog
    assign O_IRQ = ((st_q.ctl.terminal_count_flag && st_q.ctl.local_irq_enable) || I_WDT_IRQ)
        && shared_wdt_timer_irq_enable && global_irq_enable;
    assign O_WAKEUP = st_q.ctl.terminal_count_flag && st_q.ctl.local_irq_enable;

endmodule : wst_timer
`default_nettype wire

// >>> wst_timer_assertions.sv
// checker and bind of the wake-up system timer
`timescale 1ns/100ps
`default_nettype none
`include "wst_regs.svh"
module wst_timer_checker (
    input wire logic I_CLK_SYS,
    input wire logic I_RST,
    input wire logic [7:0] I_SFR_ADDR,
    input wire logic [7:0] I_SFR_WDATA,
    input wire logic I_SFR_WR,
    input wire logic I_SFR_RD,
    input wire logic [7:0] I_IRQ_ENABLE_REG0,
    input wire logic I_WDT_IRQ,
    input wire logic [7:0] O_SFR_RDATA,
    input wire logic O_IRQ,
    input wire logic O_WAKEUP
);
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (I_RST);
    wire logic en2 = &I_IRQ_ENABLE_REG0[7:6];
    wire logic wc = I_SFR_WR && I_SFR_ADDR == `WST_ADDR_CONTROL;
    wire logic rc = I_SFR_RD && I_SFR_ADDR == `WST_ADDR_CONTROL;
    wire logic wl = I_SFR_WR && I_SFR_ADDR == `WST_ADDR_RELOAD_LOW;
    wire logic rl = I_SFR_RD && I_SFR_ADDR == `WST_ADDR_RELOAD_LOW;
    wire logic ru = I_SFR_RD && (I_SFR_ADDR < 8'hD1 || I_SFR_ADDR > 8'hD3);
    chk_irq_merge: assert property (O_IRQ == ((I_WDT_IRQ | O_WAKEUP) & en2))
        else $error("bad combined request");
    chk_wake_hold: assert property (O_WAKEUP && !wc |=> O_WAKEUP)
        else $error("wake dropped");
    chk_wake_off: assert property (wc && !I_SFR_WDATA[1] |=> !O_WAKEUP)
        else $error("wake without enable");
    chk_rd_stable: assert property (!I_SFR_RD |=> $stable(O_SFR_RDATA))
        else $error("read data moved");
    chk_rd_resv: assert property (rc |=> O_SFR_RDATA[4:2] == 3'h0)
        else $error("reserved bits set");
    chk_rd_flag: assert property (rc && O_WAKEUP && !I_SFR_WR |=> O_SFR_RDATA[7] && O_SFR_RDATA[1])
        else $error("flag bits wrong");
    chk_rd_unmap: assert property (ru |=> O_SFR_RDATA == 8'h00)
        else $error("unmapped read");
    chk_reload_rb: assert property (wl ##1 !wl ##1 rl |=> O_SFR_RDATA == $past(I_SFR_WDATA, 3))
        else $error("reload readback");
    cover property ($rose(O_WAKEUP));
    cover property (O_IRQ && !I_WDT_IRQ);
    cover property (rc && O_WAKEUP);
endmodule : wst_timer_checker
bind wst_timer wst_timer_checker chk (.*);
`default_nettype wire

// >>> tb_wst_timer.sv
// testbench of the wake-up system timer
`timescale 1ns/100ps
`default_nettype none
`include "wst_regs.svh"
`define CHK(nm, e, s) begin checks_done++; if ((s) !== (e)) begin err_total++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, s); end end
module tb_wst_timer;
    logic clk = 0, rst = 1, wr = 0, rd = 0, stk = 1, xtk = 0, wdt = 0;
    logic [7:0] addr = 8'h00, wd = 8'h00, ien = 8'hC0, rdata;
    logic irq, wake;
    int err_total = 0, checks_done = 0, n;
    wst_timer dut (.I_CLK_SYS(clk), .I_RST(rst), .I_SFR_ADDR(addr), .I_SFR_WDATA(wd),
        .I_SFR_WR(wr), .I_SFR_RD(rd), .I_SYSTEM_CLOCK_TICK(stk), .I_CRYSTAL_OSC_TICK(xtk),
        .I_IRQ_ENABLE_REG0(ien), .I_WDT_IRQ(wdt), .O_SFR_RDATA(rdata), .O_IRQ(irq),
        .O_WAKEUP(wake));
    initial forever #50 clk = ~clk;
    task automatic final_report;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : final_report
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wd = d;
        wr = 1;
        @(posedge clk);
        #1 wr = 0;
        // idle cycle so that back-to-back calls never retoggle a strobe in one step
        @(posedge clk);
        #1;
    endtask : wr_reg
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string nm);
        addr = a;
        rd = 1;
        @(posedge clk);
        #1 rd = 0;
        `CHK(nm, e, rdata)
        @(posedge clk);
        #1;
    endtask : rd_chk
    // edges until the wake-up level shows
    task automatic measure(input int e);
        n = 0;
        while (!wake && n < 2000) begin
            @(posedge clk);
            #1 n++;
        end
        `CHK("period", e, n)
    endtask : measure
    initial begin
        #200000;
        err_total++;
        final_report;
    end
    initial begin
        repeat (5) @(posedge clk);
        #1 rst = 0;
        rd_chk(`WST_ADDR_CONTROL, 8'h60, "ctl");
        rd_chk(`WST_ADDR_RELOAD_HIGH, 8'h00, "hi");
        rd_chk(8'h00, 8'h00, "unmapped");
        wr_reg(`WST_ADDR_RELOAD_LOW, 8'h01);
        rd_chk(`WST_ADDR_RELOAD_LOW, 8'h01, "lo");
        $display("test registers done");
        // select 11 keeps the system clock tick, held high here so it ticks every edge; each access spends two edges
        wr_reg(`WST_ADDR_CONTROL, 8'h63);
        wr_reg(`WST_ADDR_RELOAD_LOW, 8'h00);
        // load 0xFF: 256 ticks to terminal, 3 of them spent before measuring
        measure(253);
        `CHK("irq", 1'b1, irq)
        wr_reg(`WST_ADDR_CONTROL, 8'h63);
        // reload 0x7F: 128 ticks, 2 spent by the flag-clearing write
        measure(126);
        ien = 8'h40;
        wr_reg(`WST_ADDR_CONTROL, 8'hE3);
        `CHK("irq", 1'b0, irq)
        rd_chk(`WST_ADDR_CONTROL, 8'hE3, "flag");
        $display("test reload done");
        wr_reg(`WST_ADDR_CONTROL, 8'h00);
        stk = 0;
        xtk = 1;
        wdt = 1;
        ien = 8'hC0;
        wr_reg(`WST_ADDR_CONTROL, 8'h03);
        // reload 0x7F: 128 ticks after the enabling edge, 1 spent in the idle cycle
        measure(127);
        wr_reg(`WST_ADDR_CONTROL, 8'h61);
        rd_chk(`WST_ADDR_CONTROL, 8'h01, "sel");
        $display("test source done");
        final_report;
    end
endmodule : tb_wst_timer
`default_nettype wire
